/* common/acc_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: included by bare name, definitions only
// Notes: offsets are byte addresses on the 8-bit register port
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// register offsets
`define ACC_REF_SEL_OFS 8'h2C
`define ACC_CTRL_OFS 8'h2D

// reference_select fields
`define ACC_EXT_BIT 7
`define ACC_BGAP_BIT 6
`define ACC_LVL_HI 5
`define ACC_LVL_LO 2
`define ACC_REF_RST 8'h00

// comparator_control_status fields
`define ACC_HYST_BIT 7
`define ACC_INV_BIT 5
`define ACC_FLAG_BIT 4
`define ACC_IE_BIT 3
`define ACC_CMP_BIT 2
`define ACC_ROUTE_BIT 1
`define ACC_PWR_BIT 0
`define ACC_CTRL_RST 8'h80

// timing: edge delay in ns, clock rate in MHz, delay in cycles (rounded down)
`define ACC_EDGE_DLY_NS 250
`define ACC_CLK_MHZ 20
`define ACC_EDGE_CYC ((`ACC_EDGE_DLY_NS * `ACC_CLK_MHZ) / 1000)

`endif

/* common/acc_pkg.sv */
// Purpose: types shared by the comparator control logic
// Assumes: nothing is imported, users write acc_pkg::name
// Notes: reference source codes are one-hot
package acc_pkg;

    typedef logic [7:0] acc_byte_type;

    // source driven onto the negative input
    typedef enum logic [2:0] {
        ACC_SRC_LEVEL = 3'b001,
        ACC_SRC_BGAP = 3'b010,
        ACC_SRC_EXT = 3'b100
    } acc_src_type;

endpackage

/* logic/acc_top.sv */
// Purpose: control and status logic around an on-chip analog comparator
// Assumes: inputs synchronous to clk_i; registers reached by a plain strobe port
// Notes: read data stand one cycle after the read strobe
`include "acc_regs.svh"

module acc_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic cmp_raw_i,
    output logic ext_conn_o,
    output logic bgap_conn_o,
    output logic level_en_o,
    output logic [3:0] level_o,
    output logic hyst_en_o,
    output logic power_on_o,
    output logic pin_o,
    output logic pin_oe_n_o,
    output logic irq_o
);

    localparam int DLY_CYC = `ACC_EDGE_CYC;

    acc_pkg::acc_byte_type ref_q;
    acc_pkg::acc_byte_type rd_data_q;
    acc_pkg::acc_byte_type ctrl_rd;
    acc_pkg::acc_src_type src;
    logic hyst_q;
    logic inv_q;
    logic flag_q;
    logic ie_q;
    logic cmp_q;
    logic route_q;
    logic pwr_q;
    logic comp_now;
    logic [DLY_CYC:0] dly_q;
    logic rise_ev;
    logic fall_ev;
    logic edge_ev;
    logic wr_ref;
    logic wr_ctrl;
    logic rd_ctrl;
    logic ext_q;
    logic bgap_q;
    logic lvl_en_q;
    logic [3:0] lvl_q;
    logic pin_q;
    logic pin_oe_n_q;
    logic irq_q;

    // register port decode
    assign wr_ref = wr_i && (addr_i == `ACC_REF_SEL_OFS);
    assign wr_ctrl = wr_i && (addr_i == `ACC_CTRL_OFS);
    assign rd_ctrl = rd_i && (addr_i == `ACC_CTRL_OFS);

    // reference select register, reserved low bits held at zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_q <= `ACC_REF_RST;
        end else if (clk_en_i && wr_ref) begin
            ref_q <= {wr_data_i[7:2], 2'h0};
        end
    end

    // software controlled bits of the control register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hyst_q <= 1'b1;
            inv_q <= 1'b0;
            ie_q <= 1'b0;
            route_q <= 1'b0;
            pwr_q <= 1'b0;
        end else if (clk_en_i && wr_ctrl) begin
            hyst_q <= wr_data_i[`ACC_HYST_BIT];
            inv_q <= wr_data_i[`ACC_INV_BIT];
            ie_q <= wr_data_i[`ACC_IE_BIT];
            route_q <= wr_data_i[`ACC_ROUTE_BIT];
            pwr_q <= wr_data_i[`ACC_PWR_BIT];
        end
    end

    // internal comparator signal: inverted when asked, one while powered off
    always_comb begin
        if (pwr_q) begin
            comp_now = cmp_raw_i ^ inv_q;
        end else begin
            comp_now = 1'b1;
        end
    end

    // delay line models the settling between output change and interrupt edge
    // five stages at 50 ns give the edge latency; reset fills it with the idle value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dly_q <= '1; // matches the powered-off value, no edge after reset
        end else if (clk_en_i) begin
            dly_q <= {dly_q[DLY_CYC-1:0], comp_now};
        end
    end

    // edge seen at the end of the delay line
    assign rise_ev = dly_q[DLY_CYC-1] && !dly_q[DLY_CYC];
    assign fall_ev = !dly_q[DLY_CYC-1] && dly_q[DLY_CYC];
    assign edge_ev = inv_q ? fall_ev : rise_ev;

    // interrupt flag: set by edge, cleared by read, set wins
    // the set branch comes first so an edge in the cycle of a clearing read is kept
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flag_q <= 1'b0;
        end else if (clk_en_i) begin
            if (edge_ev) begin
                flag_q <= 1'b1;
            end else if (rd_ctrl) begin
                flag_q <= 1'b0;
            end
        end
    end

    // status bit snapshot of the comparator signal
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmp_q <= 1'b0;
        end else if (clk_en_i) begin
            cmp_q <= comp_now;
        end
    end

    // pick the reference source by priority
    always_comb begin
        if (ref_q[`ACC_EXT_BIT]) begin
            src = acc_pkg::ACC_SRC_EXT;
        end else if (ref_q[`ACC_BGAP_BIT]) begin
            src = acc_pkg::ACC_SRC_BGAP;
        end else begin
            src = acc_pkg::ACC_SRC_LEVEL;
        end
    end

    // registered reference network controls
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_q <= 1'b0;
            bgap_q <= 1'b0;
            lvl_en_q <= 1'b1;
            lvl_q <= 4'h0;
        end else if (clk_en_i) begin
            lvl_q <= ref_q[`ACC_LVL_HI:`ACC_LVL_LO];
            unique case (src)
                acc_pkg::ACC_SRC_EXT: begin
                    ext_q <= 1'b1;
                    bgap_q <= 1'b0;
                    lvl_en_q <= 1'b0;
                end
                acc_pkg::ACC_SRC_BGAP: begin
                    ext_q <= 1'b0;
                    bgap_q <= 1'b1;
                    lvl_en_q <= 1'b0;
                end
                acc_pkg::ACC_SRC_LEVEL: begin
                    ext_q <= 1'b0;
                    bgap_q <= 1'b0;
                    lvl_en_q <= 1'b1;
                end
            endcase
        end
    end

    // port pin routing, enable low while driving
    // routing off parks the pin low and releases the enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else if (clk_en_i) begin
            pin_q <= route_q & comp_now;
            pin_oe_n_q <= !route_q;
        end
    end

    // interrupt request from flag and enable
    // registered so the request comes straight from a flip-flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            irq_q <= flag_q & ie_q;
        end
    end

    // control register as software sees it, reserved bit reads zero
    assign ctrl_rd = {hyst_q, 1'b0, inv_q, flag_q, ie_q, cmp_q, route_q, pwr_q};

    // read data, zero for unmapped offsets
    // fixed one cycle latency, the port never stalls the master
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_q <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_i && addr_i == `ACC_REF_SEL_OFS) begin
                rd_data_q <= ref_q;
            end else if (rd_ctrl) begin
                rd_data_q <= ctrl_rd;
            end else begin
                rd_data_q <= 8'h00;
            end
        end
    end

    // outputs straight from flip-flops
    assign rd_data_o = rd_data_q;
    assign ext_conn_o = ext_q;
    assign bgap_conn_o = bgap_q;
    assign level_en_o = lvl_en_q;
    assign level_o = lvl_q;
    assign hyst_en_o = hyst_q;
    assign power_on_o = pwr_q;
    assign pin_o = pin_q;
    assign pin_oe_n_o = pin_oe_n_q;
    assign irq_o = irq_q;

    // checks, frozen cycles and reset excluded
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i || !clk_en_i);

    ext_sel_a: assert property (ref_q[7] |=> ext_conn_o && !bgap_conn_o && !level_en_o)
        else $error("external reference not selected");

    bgap_sel_a: assert property (!ref_q[7] && ref_q[6] |=> bgap_conn_o && !ext_conn_o && !level_en_o)
        else $error("bandgap reference not selected");

    level_sel_a: assert property (ref_q[7:6] == 2'h0 |=> level_en_o && level_o == $past(ref_q[5:2]))
        else $error("level field not applied");

    ref_reset_a: assert property ($past(sys_rst_i) |-> ref_q == 8'h00 && !ext_conn_o && !bgap_conn_o)
        else $error("reference register not reset");

    ctrl_reset_a: assert property ($past(sys_rst_i) |-> ctrl_rd[7:2] == 6'h20 && !pwr_q && !route_q)
        else $error("control register not 80h after reset");

    result_inv_a: assert property (pwr_q && !wr_ctrl |=> cmp_q == ($past(cmp_raw_i) ^ inv_q))
        else $error("status bit not the inverted result");

    rise_edge_a: assert property (!inv_q && !dly_q[DLY_CYC] && dly_q[DLY_CYC-1] |=> flag_q)
        else $error("rising edge did not set flag");

    fall_edge_a: assert property (inv_q && dly_q[DLY_CYC] && !dly_q[DLY_CYC-1] |=> flag_q)
        else $error("falling edge did not set flag");

    wrong_edge_a: assert property (!inv_q && fall_ev && !flag_q |=> !flag_q)
        else $error("wrong edge set flag");

    read_clear_a: assert property (rd_ctrl && !edge_ev |=> !flag_q)
        else $error("read did not clear flag");

    write_keep_a: assert property (wr_ctrl && !edge_ev |=> flag_q == $past(flag_q))
        else $error("write changed flag");

    irq_gate_a: assert property (##1 irq_o == $past(flag_q && ie_q))
        else $error("interrupt not flag and enable");

    pin_route_a: assert property (route_q |=> !pin_oe_n_o && pin_o == $past(comp_now))
        else $error("pin not driven with result");

    pin_off_a: assert property (!route_q |=> pin_oe_n_o && !pin_o)
        else $error("pin driven while not routed");

    power_out_a: assert property (wr_ctrl |=> power_on_o == $past(wr_data_i[`ACC_PWR_BIT]))
        else $error("power output mismatch");

    edge_delay_a: assert property ((comp_now != dly_q[0]) |-> ##DLY_CYC (dly_q[DLY_CYC-1] != dly_q[DLY_CYC]))
        else $error("edge not delayed by the set count");

    off_one_a: assert property (!pwr_q |=> cmp_q)
        else $error("powered off result not one");

    set_wins_a: assert property (edge_ev && rd_ctrl |=> flag_q)
        else $error("edge lost against clearing read");

    // writes, read-back and output gating
    ref_write_a: assert property (wr_ref |=> ref_q[7:2] == $past(wr_data_i[7:2]))
        else $error("reference write not applied");

    ext_off_a: assert property (!ref_q[7] |=> !ext_conn_o)
        else $error("external reference connected while not selected");

    bgap_off_a: assert property (ref_q[7] || !ref_q[6] |=> !bgap_conn_o)
        else $error("bandgap connected while not selected");

    hyst_write_a: assert property (wr_ctrl |=> hyst_en_o == $past(wr_data_i[`ACC_HYST_BIT]))
        else $error("hysteresis write not applied");

    rise_wrong_a: assert property (inv_q && rise_ev && !flag_q |=> !flag_q)
        else $error("rising edge set flag while inverted");

    no_edge_a: assert property (!flag_q && !edge_ev |=> !flag_q)
        else $error("flag set without an edge");

    flag_hold_a: assert property (flag_q && !rd_ctrl |=> flag_q)
        else $error("flag lost without a read");

    ie_write_a: assert property (wr_ctrl |=> ie_q == $past(wr_data_i[`ACC_IE_BIT]))
        else $error("interrupt enable write not applied");

    irq_off_a: assert property (!ie_q |=> !irq_o)
        else $error("interrupt requested while disabled");

    status_read_a: assert property (rd_ctrl |=> rd_data_o[`ACC_CMP_BIT] == $past(cmp_q))
        else $error("status bit not read back");

    off_pin_a: assert property (route_q && !pwr_q |=> pin_o)
        else $error("routed pin not one while powered off");

    // main scenarios
    flag_set_c: cover property (!flag_q ##1 flag_q);
    irq_req_c: cover property (ie_q && flag_q ##1 irq_o);
    clash_c: cover property (edge_ev && rd_ctrl);
    ext_src_c: cover property (ext_conn_o && pwr_q);
    inv_fall_c: cover property (inv_q && fall_ev);

endmodule

/* verification/acc_cmp_model.sv */
// Purpose: behavioural analog comparator with its reference network
// Assumes: voltages are given in millivolts by the bench
// Notes: output is 0 while unpowered; the control logic forces its own value then
module acc_cmp_model (
    input wire logic power_on_i,
    input wire logic ext_conn_i,
    input wire logic bgap_conn_i,
    input wire logic level_en_i,
    input wire logic [3:0] level_i,
    input wire logic [15:0] pos_mv_i,
    input wire logic [15:0] ext_mv_i,
    output logic cmp_raw_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int neg_mv;
    // negative input from the selected source, then the comparison
    always_comb begin
        if (ext_conn_i) neg_mv = int'(ext_mv_i);
        else if (bgap_conn_i) neg_mv = 1200;
        else if (level_en_i) neg_mv = 200 * (int'(level_i) + 1);
        else neg_mv = 0;
        cmp_raw_o = power_on_i && (int'(pos_mv_i) > neg_mv);
    end
endmodule

/* verification/tb.sv */
// Purpose: self-checking bench for the comparator control logic
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: reference writes run from a table, interrupt cases are hand-written
`include "acc_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] d; logic [6:0] o;} acc_row_type;
    logic clk, rst, clk_en, wr, rd, raw, ext, bgap, lvl_en, hyst, pwr, pin, pin_oe_n, irq;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] lvl;
    logic [15:0] pos_mv, vext;
    int bad_count, cmp_count, cyc;
    // reserved low bits are always written as zero
    acc_row_type rows [6] = '{'{8'h80, 7'h40}, '{8'hF8, 7'h40}, '{8'h7C, 7'h20},
                              '{8'h3C, 7'h1F}, '{8'h00, 7'h10}, '{8'h14, 7'h15}};
    acc_top DUT (.clk_i(clk), .sys_rst_i(rst), .clk_en_i(clk_en), .addr_i(addr), .wr_data_i(wdata),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .cmp_raw_i(raw), .ext_conn_o(ext), .bgap_conn_o(bgap),
        .level_en_o(lvl_en), .level_o(lvl), .hyst_en_o(hyst), .power_on_o(pwr), .pin_o(pin),
        .pin_oe_n_o(pin_oe_n), .irq_o(irq));
    acc_cmp_model far_end (.power_on_i(pwr), .ext_conn_i(ext), .bgap_conn_i(bgap), .level_en_i(lvl_en),
        .level_i(lvl), .pos_mv_i(pos_mv), .ext_mv_i(vext), .cmp_raw_o(raw));
    // free-running clock
    always #25 clk = ~clk;
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one write cycle, then an idle cycle so strobes never reassign in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // one read cycle, data looked at in the following cycle only
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge clk);
    endtask
    task automatic wait_settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        pos_mv = 16'h01F4;
        vext = 16'h07D0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 chk({3'h0, hyst, pwr, pin_oe_n, irq, lvl_en}, 8'h15);
        wait_settle(2);
        rd_reg(`ACC_REF_SEL_OFS, 8'h00);
        rd_reg(`ACC_CTRL_OFS, 8'h84);
        wr_reg(8'h2E, 8'hFF);
        rd_reg(8'h2E, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr_reg(`ACC_REF_SEL_OFS, rows[i].d);
            #1 chk({1'b0, ext, bgap, lvl_en, lvl_en ? lvl : 4'h0}, {1'b0, rows[i].o});
            rd_reg(`ACC_REF_SEL_OFS, rows[i].d);
        end
        // level 4 gives 1.0V against 0.5V: signal low once powered
        wr_reg(`ACC_REF_SEL_OFS, 8'h10);
        wr_reg(`ACC_CTRL_OFS, 8'h83);
        wait_settle(12);
        rd_reg(`ACC_CTRL_OFS, 8'h83);
        chk(8'(pin_oe_n), 8'h00);
        wr_reg(`ACC_CTRL_OFS, 8'h8B);
        pos_mv <= 16'h05DC;
        // flag lands six edges after the change, the request one edge later
        wait_settle(6);
        chk(8'(irq), 8'h00);
        wait_settle(1);
        chk({6'h00, irq, pin}, 8'h03);
        rd_reg(`ACC_CTRL_OFS, 8'h9F);
        rd_reg(`ACC_CTRL_OFS, 8'h8F);
        chk(8'(irq), 8'h00);
        wr_reg(`ACC_CTRL_OFS, 8'h9B);
        rd_reg(`ACC_CTRL_OFS, 8'h8F);
        pos_mv <= 16'h01F4;
        wait_settle(10);
        rd_reg(`ACC_CTRL_OFS, 8'h8B);
        wr_reg(`ACC_CTRL_OFS, 8'h83);
        pos_mv <= 16'h05DC;
        // the read is taken at the very edge that sees the rising event
        wait_settle(5);
        rd_reg(`ACC_CTRL_OFS, 8'h87);
        rd_reg(`ACC_CTRL_OFS, 8'h97);
        chk(8'(irq), 8'h00);
        // inverting turns the high signal low, a falling edge
        wr_reg(`ACC_CTRL_OFS, 8'hA3);
        wait_settle(10);
        chk(8'(pin), 8'h00);
        rd_reg(`ACC_CTRL_OFS, 8'hB3);
        pos_mv <= 16'h01F4;
        wait_settle(10);
        rd_reg(`ACC_CTRL_OFS, 8'hA7);
        // power off with routing kept: the pin shows the forced one
        wr_reg(`ACC_CTRL_OFS, 8'h02);
        wait_settle(3);
        rd_reg(`ACC_CTRL_OFS, 8'h06);
        chk({5'h00, pin, hyst, pwr}, 8'h04);
        clk_en <= 1'b0;
        wr_reg(`ACC_CTRL_OFS, 8'h01);
        clk_en <= 1'b1;
        #1 chk(8'(pwr), 8'h00);
        wrap_up();
    end
endmodule
